/* hdl/acr_pkg.sv */
// constants for the adc status and correction register bank
package acr_pkg;
  // register addresses on the serial port
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CTRL2 = 3'h2;
  localparam logic [2:0] ADDR_OFFSET = 3'h3;
  localparam logic [2:0] ADDR_GAIN = 3'h4;
  localparam logic [2:0] ADDR_THRESH = 3'h5;
  // reset values
  localparam logic [15:0] CTRL1_RST = 16'h001A;
  localparam logic [15:0] CTRL2_RST = 16'h009B;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'hA000;
  localparam logic [15:0] THRESH_RST = 16'hCCCC;
  // first control register fields
  localparam int C1_RD_OVR = 14;
  localparam int C1_RD_GAIN = 13;
  localparam int C1_RD_OFF = 12;
  localparam int C1_RD_STAT = 11;
  localparam int C1_BYP = 4;
  localparam int C1_DEC_LO = 0;
  // second control register fields
  localparam int C2_LOW_POWER_FLAG = 2;
  // status word fields
  localparam int ST_PART_LO = 14;
  localparam int ST_INST_LO = 11;
  localparam int ST_ZERO = 10;
  localparam int ST_LOW_POWER_FLAG = 9;
  localparam int ST_OVR = 8;
  localparam int ST_COEFF_LOAD_CHECK_PASS = 7;
  localparam int ST_FILT_OK = 6;
  localparam int ST_CUSTOM = 5;
  localparam int ST_BYP = 4;
  localparam int ST_ONE = 3;
  localparam int ST_DEC_LO = 0;
  // correction arithmetic
  localparam int RES_W = 24;
  localparam int GAIN_SHIFT = 15;
  // modulator clip run: flag once the run exceeds this count
  localparam logic [2:0] CLIP_RUN_MAX = 3'h4;
  // magnitude bits compared with the 16-bit threshold
  localparam int MAG_CMP_LO = 7;
  // read source selection, one-hot
  typedef enum logic [4:0] {
    RSEL_CONV = 5'b00001,
    RSEL_STATUS = 5'b00010,
    RSEL_OFFSET = 5'b00100,
    RSEL_GAIN = 5'b01000,
    RSEL_THRESH = 5'b10000
  } acr_rsel_t;
endpackage

/* hdl/acr_correct.sv */
// gain then offset correction with saturation of conversion results
`timescale 1ns/1ns
module acr_correct import acr_pkg::*; (
  input wire logic clk, // master clock
  input wire logic arst_n, // async reset, active low
  input wire logic in_valid, // new raw result
  input wire logic signed [RES_W-1:0] in_data, // raw result
  input wire logic [15:0] gain, // unsigned gain, 0x8000 is unity
  input wire logic signed [15:0] offset, // signed offset word
  output logic out_valid, // corrected result valid
  output logic signed [RES_W-1:0] out_data // corrected result
);
  localparam int PROD_W = RES_W + 17;
  localparam int SUM_W = PROD_W - GAIN_SHIFT + 1;
  localparam logic signed [SUM_W-1:0] MAX_RES = SUM_W'((1 << (RES_W-1)) - 1);
  localparam logic signed [SUM_W-1:0] MIN_RES = -SUM_W'(1 << (RES_W-1));

  logic signed [PROD_W-1:0] prod;
  logic signed [SUM_W-1:0] sum;
  logic out_valid_d;
  logic signed [RES_W-1:0] out_data_d;

  always_comb begin
    prod = in_data * $signed({1'b0, gain});
    // full offset code is 1/256 of full scale
    sum = SUM_W'(prod >>> GAIN_SHIFT) + SUM_W'(offset);
    out_valid_d = in_valid;
    out_data_d = out_data;
    if (in_valid) begin
      if (sum > MAX_RES) begin
        out_data_d = MAX_RES[RES_W-1:0];
      end else if (sum < MIN_RES) begin
        out_data_d = MIN_RES[RES_W-1:0];
      end else begin
        out_data_d = sum[RES_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= out_valid_d;
      out_data <= out_data_d;
    end
  end
endmodule // acr_correct

/* hdl/acr_regs.sv */
// status word, correction and overrange registers of the adc back end
//
// Functional notes
// - status bits 15:14 hold fixed family code
// - status bits 13:11 report instance number
// - status bit 10 always reads zero
// - status bit 3 reads one once out of reset
// - status bit 9 shows reduced-power mode
// - bit 8 set when level exceeds threshold
// - bit 7 set when download checksum matches
// - bit 6 set when runtime filter checksum matches while custom filter used
// - bit 5 set while custom filter used
// - bit 4 mirrors third-stage bypass setting
// - bits 2:0 echo programmed decimation code
// - offset signed, full code is 0.390625%
// - offset added after gain correction
// - gain unsigned, 0x8000 means unity
// - gain resets to 0xA000, 1.25
// - threshold compared with first-stage output
// - threshold resets to 0xCCCC, 80 percent
// - more than 4 clipped samples sets flag
// - status request makes next read status
// - register request makes next read that register
`timescale 1ns/1ns
module acr_regs import acr_pkg::*; #(
  parameter int CSUM_W = 16, // checksum and coefficient word width
  parameter logic [1:0] PART_ID = 2'h1 // family code, value arbitrary
) (
  input wire logic REF_CLK, // master clock
  input wire logic ARST_N, // async reset, active low
  input wire logic WR_STB, // register write from serial port
  input wire logic [2:0] WR_ADDR, // register address
  input wire logic [15:0] WR_DATA, // register data word
  input wire logic RD_STB, // read operation from serial port
  output logic [RES_W-1:0] RD_DATA, // read word
  output logic RD_VALID, // read word valid pulse
  input wire logic [2:0] INST_ID, // instance strap pins
  input wire logic STAGE1_VALID, // first decimation stage sample
  input wire logic [RES_W-1:0] STAGE1_DATA, // first stage output
  input wire logic MOD_VALID, // modulator-rate sample tick
  input wire logic MOD_CLIP, // modulator input beyond full reference
  input wire logic COEF_LOAD_START, // coefficient download begins
  input wire logic COEF_STB, // coefficient word loaded
  input wire logic [CSUM_W-1:0] COEF_DATA, // coefficient word
  input wire logic COEF_SUM_STB, // checksum word after coefficients
  input wire logic [CSUM_W-1:0] COEF_SUM_DATA, // downloaded checksum
  input wire logic FILT_PASS_START, // filter coefficient pass begins
  input wire logic FILT_COEF_STB, // coefficient passed through filter
  input wire logic [CSUM_W-1:0] FILT_COEF_DATA, // passed coefficient
  input wire logic FILT_PASS_DONE, // filter coefficient pass ends
  input wire logic CUSTOM_FIR_ACTIVE, // custom coefficients in use
  input wire logic CONV_VALID, // raw conversion result valid
  input wire logic [RES_W-1:0] CONV_DATA, // raw conversion result
  output logic RES_VALID, // corrected result valid pulse
  output logic [RES_W-1:0] RES_DATA, // corrected result
  output logic [15:0] STATUS_WORD, // live status word
  output logic THIRD_STAGE_BYPASS, // bypass setting to filter
  output logic [2:0] STAGE_TWO_RATIO_CODE, // decimation code
  output logic LOW_POWER_FLAG // reduced-power mode
);
  if (CSUM_W < 1 || CSUM_W > 32) begin : g_chk
    $error("CSUM_W must lie between 1 and 32");
  end

  function automatic logic [CSUM_W-1:0] csum_add(
    input logic [CSUM_W-1:0] acc,
    input logic [CSUM_W-1:0] word
  );
    csum_add = CSUM_W'(acc + word);
  endfunction

  function automatic logic [RES_W-2:0] magnitude(
    input logic [RES_W-1:0] x
  );
    logic [RES_W-1:0] neg;
    neg = RES_W'(~x + 1'b1);
    if (!x[RES_W-1]) begin
      magnitude = x[RES_W-2:0];
    end else if (neg[RES_W-1]) begin
      magnitude = '1;
    end else begin
      magnitude = neg[RES_W-2:0];
    end
  endfunction

  // instance strap synchroniser
  logic [2:0] inst_s1_q, inst_s2_q;

  // register file
  logic [15:0] offset_correction_q, offset_correction_d;
  logic [15:0] gain_correction_q, gain_correction_d;
  logic [15:0] overrange_threshold_q, overrange_threshold_d;
  logic bypass_q, bypass_d;
  logic [2:0] ratio_q, ratio_d;
  logic low_power_flag_q, low_power_flag_d;
  acr_rsel_t rsel_q, rsel_d;
  logic [RES_W-1:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;

  // checks and overrange
  logic [CSUM_W-1:0] dl_sum_q, dl_sum_d;
  logic [CSUM_W-1:0] loaded_sum_q, loaded_sum_d;
  logic [CSUM_W-1:0] filt_sum_q, filt_sum_d;
  logic coeff_load_check_pass_q, coeff_load_check_pass_d;
  logic filt_ok_q, filt_ok_d;
  logic custom_q, custom_d;
  logic [2:0] clip_cnt_q, clip_cnt_d;
  logic ovr_q, ovr_d;
  logic [15:0] status_q, status_d;
  logic [RES_W-2:0] stage1_mag;
  logic [RES_W-1:0] res_data;
  logic res_valid;

  // register writes and read selection
  always_comb begin
    offset_correction_d = offset_correction_q;
    gain_correction_d = gain_correction_q;
    overrange_threshold_d = overrange_threshold_q;
    bypass_d = bypass_q;
    ratio_d = ratio_q;
    low_power_flag_d = low_power_flag_q;
    rsel_d = rsel_q;
    rd_valid_d = RD_STB;
    rd_data_d = rd_data_q;
    if (RD_STB) begin
      case (rsel_q)
        RSEL_STATUS: rd_data_d = {status_q, 8'h00};
        RSEL_OFFSET: rd_data_d = {offset_correction_q, 8'h00};
        RSEL_GAIN: rd_data_d = {gain_correction_q, 8'h00};
        RSEL_THRESH: rd_data_d = {overrange_threshold_q, 8'h00};
        RSEL_CONV: rd_data_d = res_data;
        default: rd_data_d = res_data;
      endcase
      rsel_d = RSEL_CONV;
    end
    if (WR_STB) begin
      case (WR_ADDR)
        ADDR_CTRL1: begin
          bypass_d = WR_DATA[C1_BYP];
          ratio_d = WR_DATA[C1_DEC_LO +: 3];
          if (WR_DATA[C1_RD_OVR]) begin
            rsel_d = RSEL_THRESH;
          end else if (WR_DATA[C1_RD_GAIN]) begin
            rsel_d = RSEL_GAIN;
          end else if (WR_DATA[C1_RD_OFF]) begin
            rsel_d = RSEL_OFFSET;
          end else if (WR_DATA[C1_RD_STAT]) begin
            rsel_d = RSEL_STATUS;
          end
        end
        ADDR_CTRL2: low_power_flag_d = WR_DATA[C2_LOW_POWER_FLAG];
        ADDR_OFFSET: offset_correction_d = WR_DATA;
        ADDR_GAIN: gain_correction_d = WR_DATA;
        ADDR_THRESH: overrange_threshold_d = WR_DATA;
        default: ;
      endcase
    end
  end

  // checksums, overrange and status word
  always_comb begin
    dl_sum_d = dl_sum_q;
    loaded_sum_d = loaded_sum_q;
    filt_sum_d = filt_sum_q;
    coeff_load_check_pass_d = coeff_load_check_pass_q;
    filt_ok_d = filt_ok_q;
    custom_d = CUSTOM_FIR_ACTIVE;
    clip_cnt_d = clip_cnt_q;
    ovr_d = ovr_q;
    stage1_mag = magnitude(STAGE1_DATA);
    if (COEF_LOAD_START) begin
      dl_sum_d = '0;
      coeff_load_check_pass_d = 1'b0;
    end else if (COEF_STB) begin
      dl_sum_d = csum_add(dl_sum_q, COEF_DATA);
    end else if (COEF_SUM_STB) begin
      loaded_sum_d = COEF_SUM_DATA;
      coeff_load_check_pass_d = (dl_sum_q == COEF_SUM_DATA);
    end
    if (FILT_PASS_START) begin
      filt_sum_d = '0;
    end else if (FILT_COEF_STB) begin
      filt_sum_d = csum_add(filt_sum_q, FILT_COEF_DATA);
    end else if (FILT_PASS_DONE) begin
      filt_ok_d = custom_q && (filt_sum_q == loaded_sum_q);
    end
    if (MOD_VALID) begin
      if (!MOD_CLIP) begin
        clip_cnt_d = 3'h0;
      end else if (clip_cnt_q <= CLIP_RUN_MAX) begin
        clip_cnt_d = clip_cnt_q + 3'h1;
      end
    end
    if (clip_cnt_d > CLIP_RUN_MAX) begin
      ovr_d = 1'b1;
    end else if (STAGE1_VALID) begin
      ovr_d = stage1_mag[MAG_CMP_LO +: 16] > overrange_threshold_q;
    end
    status_d = '0;
    status_d[ST_PART_LO +: 2] = PART_ID;
    status_d[ST_INST_LO +: 3] = inst_s2_q;
    status_d[ST_ZERO] = 1'b0;
    status_d[ST_LOW_POWER_FLAG] = low_power_flag_q;
    status_d[ST_OVR] = ovr_q;
    status_d[ST_COEFF_LOAD_CHECK_PASS] = coeff_load_check_pass_q;
    status_d[ST_FILT_OK] = filt_ok_q;
    status_d[ST_CUSTOM] = custom_q;
    status_d[ST_BYP] = bypass_q;
    status_d[ST_ONE] = 1'b1;
    status_d[ST_DEC_LO +: 3] = ratio_q;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      inst_s1_q <= 3'h0;
      inst_s2_q <= 3'h0;
      offset_correction_q <= OFFSET_RST;
      gain_correction_q <= GAIN_RST;
      overrange_threshold_q <= THRESH_RST;
      bypass_q <= CTRL1_RST[C1_BYP];
      ratio_q <= CTRL1_RST[C1_DEC_LO +: 3];
      low_power_flag_q <= CTRL2_RST[C2_LOW_POWER_FLAG];
      rsel_q <= RSEL_CONV;
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
      dl_sum_q <= '0;
      loaded_sum_q <= '0;
      filt_sum_q <= '0;
      coeff_load_check_pass_q <= 1'b0;
      filt_ok_q <= 1'b0;
      custom_q <= 1'b0;
      clip_cnt_q <= 3'h0;
      ovr_q <= 1'b0;
      status_q <= 16'h0000;
    end else begin
      inst_s1_q <= INST_ID;
      inst_s2_q <= inst_s1_q;
      offset_correction_q <= offset_correction_d;
      gain_correction_q <= gain_correction_d;
      overrange_threshold_q <= overrange_threshold_d;
      bypass_q <= bypass_d;
      ratio_q <= ratio_d;
      low_power_flag_q <= low_power_flag_d;
      rsel_q <= rsel_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      dl_sum_q <= dl_sum_d;
      loaded_sum_q <= loaded_sum_d;
      filt_sum_q <= filt_sum_d;
      coeff_load_check_pass_q <= coeff_load_check_pass_d;
      filt_ok_q <= filt_ok_d;
      custom_q <= custom_d;
      clip_cnt_q <= clip_cnt_d;
      ovr_q <= ovr_d;
      status_q <= status_d;
    end
  end

  // gain then offset on every result
  acr_correct u_correct (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .in_valid(CONV_VALID),
    .in_data(CONV_DATA),
    .gain(gain_correction_q),
    .offset(offset_correction_q),
    .out_valid(res_valid),
    .out_data(res_data)
  );

  assign RD_DATA = rd_data_q;
  assign RD_VALID = rd_valid_q;
  assign RES_VALID = res_valid;
  assign RES_DATA = res_data;
  assign STATUS_WORD = status_q;
  assign THIRD_STAGE_BYPASS = bypass_q;
  assign STAGE_TWO_RATIO_CODE = ratio_q;
  assign LOW_POWER_FLAG = low_power_flag_q;
endmodule // acr_regs

/* sim/acr_regs_asserts.sv */
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module acr_regs_asserts import acr_pkg::*; #(
  parameter logic [1:0] PART_ID = 2'h1 // family code, value arbitrary
) (
  input wire logic REF_CLK, // clock
  input wire logic ARST_N, // reset
  input wire logic WR_STB, // write
  input wire logic [2:0] WR_ADDR, // address
  input wire logic [15:0] WR_DATA, // data
  input wire logic RD_STB, // read
  input wire logic RD_VALID, // read valid
  input wire logic CONV_VALID, // raw valid
  input wire logic RES_VALID, // result valid
  input wire logic MOD_VALID, // modulator tick
  input wire logic MOD_CLIP, // clip
  input wire logic [15:0] STATUS_WORD, // status
  input wire logic THIRD_STAGE_BYPASS, // bypass
  input wire logic [2:0] STAGE_TWO_RATIO_CODE, // ratio
  input wire logic LOW_POWER_FLAG // low power
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic [15:0] s;
  assign s = STATUS_WORD;
  a_part_fix: assert property ($past(ARST_N) |-> s[15:14] == PART_ID)
    else $error("family code wrong");
  a_zero_bit: assert property ($past(ARST_N) |-> !s[ST_ZERO])
    else $error("status bit 10 not zero");
  a_ctrl_echo: assert property ($past(ARST_N) |-> s[4:0] ==
    {$past(THIRD_STAGE_BYPASS), 1'b1, $past(STAGE_TWO_RATIO_CODE)})
    else $error("status low bits wrong");
  a_low_power_flag_bit: assert property ($past(ARST_N) |->
    s[ST_LOW_POWER_FLAG] == $past(LOW_POWER_FLAG)) else $error("low power bit wrong");
  a_ctrl_write: assert property (WR_STB && WR_ADDR == ADDR_CTRL1 |=>
    STAGE_TWO_RATIO_CODE == $past(WR_DATA[2:0]))
    else $error("ratio code not taken");
  a_rd_pulse: assert property ($past(ARST_N) |->
    RD_VALID == $past(RD_STB)) else $error("read answer late");
  a_res_pulse: assert property ($past(ARST_N) |->
    RES_VALID == $past(CONV_VALID)) else $error("result valid wrong");
  a_clip_flag: assert property ((MOD_VALID && MOD_CLIP)[*5] |->
    ##2 s[ST_OVR]) else $error("clip run not flagged");
  c_stat_req: cover property (WR_STB && WR_DATA[C1_RD_STAT]);
  c_clip_run: cover property ((MOD_VALID && MOD_CLIP)[*5]);
  c_ovr_rise: cover property ($rose(s[ST_OVR]));
endmodule // acr_regs_asserts
bind acr_regs acr_regs_asserts #(.PART_ID(PART_ID)) u_chk (
  .REF_CLK, .ARST_N, .WR_STB, .WR_ADDR, .WR_DATA, .RD_STB, .RD_VALID,
  .CONV_VALID, .RES_VALID, .MOD_VALID, .MOD_CLIP, .STATUS_WORD,
  .THIRD_STAGE_BYPASS, .STAGE_TWO_RATIO_CODE, .LOW_POWER_FLAG
);

/* sim/acr_host.sv */
// host controller model on the register port
`timescale 1ns/1ns
module acr_host import acr_pkg::*; (
  input wire logic clk, // master clock
  output logic wr_stb, // write strobe
  output logic [2:0] wr_addr, // address
  output logic [15:0] wr_data, // data word
  output logic rd_stb, // read strobe
  input wire logic rd_valid, // read answer
  input wire logic [23:0] rd_data // read word
);
  logic [15:0] c1_q = CTRL1_RST;
  initial begin
    {wr_stb, rd_stb, wr_addr, wr_data} = '0;
  end
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    if (a == ADDR_CTRL1)
      c1_q = d & 16'h001F;
    @(posedge clk);
    wr_stb <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask
  task automatic req(input int b);
    wr(ADDR_CTRL1, c1_q | (16'h0001 << b));
  endtask
  task automatic rd(output logic [23:0] q);
    @(posedge clk);
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    q = (rd_valid === 1'b1) ? rd_data : 24'hXXXXXX;
  endtask
endmodule // acr_host

/* sim/test_acr_regs.sv */
// self-checking bench for the status and correction registers
`timescale 1ns/1ns
module test_acr_regs import acr_pkg::*; ;
  logic clk, arst_n, wr_stb, rd_stb, rd_valid, s1_v, mod_v, mod_c;
  logic custom, cv, res_v, dl, go, stb, fin, byp, lp;
  logic [2:0] wr_addr, inst, ratio;
  logic [15:0] wr_data, dat, sum_data, st;
  logic [23:0] rd_data, s1_d, conv_d, res_d, q;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  acr_regs dut (
    .REF_CLK(clk), .ARST_N(arst_n), .WR_STB(wr_stb), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .INST_ID(inst), .STAGE1_VALID(s1_v),
    .STAGE1_DATA(s1_d), .MOD_VALID(mod_v), .MOD_CLIP(mod_c),
    .COEF_LOAD_START(go & dl), .COEF_STB(stb & dl), .COEF_DATA(dat),
    .COEF_SUM_STB(fin & dl), .COEF_SUM_DATA(sum_data),
    .FILT_PASS_START(go & ~dl), .FILT_COEF_STB(stb & ~dl),
    .FILT_COEF_DATA(dat), .FILT_PASS_DONE(fin & ~dl),
    .CUSTOM_FIR_ACTIVE(custom), .CONV_VALID(cv), .CONV_DATA(conv_d),
    .RES_VALID(res_v), .RES_DATA(res_d), .STATUS_WORD(st),
    .THIRD_STAGE_BYPASS(byp), .STAGE_TWO_RATIO_CODE(ratio),
    .LOW_POWER_FLAG(lp)
  );
  acr_host host (.clk(clk), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_valid(rd_valid),
    .rd_data(rd_data));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [23:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rq(input int b, input string n, input logic [23:0] e);
    host.req(b);
    host.rd(q);
    chk(n, e, q);
  endtask
  task automatic conv(input logic [23:0] x, e);
    @(posedge clk);
    cv <= 1'b1;
    conv_d <= x;
    @(posedge clk);
    cv <= 1'b0;
    #1;
    chk("result", e, res_d);
  endtask
  task automatic s1(input logic [23:0] x, input logic e);
    @(posedge clk);
    s1_v <= 1'b1;
    s1_d <= x;
    @(posedge clk);
    s1_v <= 1'b0;
    wt(1);
    chk("overrange", 24'(e), 24'(st[ST_OVR]));
  endtask
  task automatic clip(input int n, input logic e);
    @(posedge clk);
    mod_c <= 1'b1;
    repeat (n) @(posedge clk);
    mod_c <= 1'b0;
    wt(2);
    chk("clip flag", 24'(e), 24'(st[ST_OVR]));
  endtask
  task automatic sums(input logic d, input logic [15:0] s);
    @(posedge clk);
    dl <= d;
    go <= 1'b1;
    for (int i = 1; i < 4; i++) begin
      @(posedge clk);
      go <= 1'b0;
      stb <= 1'b1;
      dat <= 16'(i);
    end
    @(posedge clk);
    stb <= 1'b0;
    fin <= 1'b1;
    sum_data <= s;
    @(posedge clk);
    fin <= 1'b0;
    wt(1);
  endtask
  task automatic t_resets;
    host.wr(3'h7, 16'h1234);
    rq(C1_RD_GAIN, "gain", 24'hA00000);
    rq(C1_RD_OFF, "offset", 24'h000000);
    rq(C1_RD_OVR, "threshold", 24'hCCCC00);
    $display("reset values done");
  endtask
  task automatic t_status;
    host.wr(ADDR_CTRL2, 16'h009F);
    host.wr(ADDR_CTRL1, 16'h001D);
    rq(C1_RD_STAT, "status", 24'h6A1D00);
    chk("controls", 24'h00001D, 24'({lp, byp, ratio}));
    host.wr(ADDR_CTRL2, 16'h009B);
    host.wr(ADDR_CTRL1, 16'h0008);
    // new strap value needs two sync edges plus the status register
    inst <= 3'h2;
    wt(3);
    chk("status", 24'h005008, 24'(st));
    chk("controls", 24'h000000, 24'({lp, byp, ratio}));
    $display("status done");
  endtask
  task automatic t_corr;
    host.wr(ADDR_GAIN, 16'h8000);
    host.wr(ADDR_OFFSET, 16'h0010);
    conv(24'h001000, 24'h001010);
    host.wr(ADDR_GAIN, 16'hA000);
    host.wr(ADDR_OFFSET, 16'hFFFF);
    conv(24'h100000, 24'h13FFFF);
    host.wr(ADDR_GAIN, 16'hFFFF);
    conv(24'h7FFFFF, 24'h7FFFFF);
    conv(24'h800000, 24'h800000);
    host.rd(q);
    chk("plain read", 24'h800000, q);
    $display("correction done");
  endtask
  task automatic t_ovr;
    host.wr(ADDR_THRESH, 16'h1000);
    rq(C1_RD_OVR, "threshold", 24'h100000);
    s1(24'h090000, 1'b1);
    s1(24'h070000, 1'b0);
    s1(24'hF70000, 1'b1);
    s1(24'h070000, 1'b0);
    clip(4, 1'b0);
    clip(5, 1'b1);
    s1(24'h000100, 1'b0);
    $display("overrange done");
  endtask
  task automatic t_sums;
    @(posedge clk);
    custom <= 1'b1;
    sums(1'b1, 16'h0006);
    chk("load ok", 24'h1, 24'(st[ST_COEFF_LOAD_CHECK_PASS]));
    sums(1'b0, 16'h0000);
    chk("filter ok", 24'h3, 24'(st[6:5]));
    sums(1'b1, 16'h0007);
    chk("load ok", 24'h0, 24'(st[ST_COEFF_LOAD_CHECK_PASS]));
    sums(1'b0, 16'h0000);
    chk("filter ok", 24'h1, 24'(st[6:5]));
    @(posedge clk);
    custom <= 1'b0;
    wt(2);
    chk("custom", 24'h0, 24'(st[ST_CUSTOM]));
    $display("checksums done");
  endtask
  task automatic t_rerst;
    @(posedge clk);
    arst_n <= 1'b0;
    wt(2);
    @(posedge clk);
    arst_n <= 1'b1;
    rq(C1_RD_GAIN, "gain", 24'hA00000);
    rq(C1_RD_OVR, "threshold", 24'hCCCC00);
    $display("reset rerun done");
  endtask
  initial begin
    {arst_n, s1_v, mod_c, custom, cv, dl, go, stb, fin} = '0;
    {s1_d, conv_d, dat, sum_data} = '0;
    mod_v = 1'b1;
    inst = 3'h5;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_resets();
    t_status();
    t_corr();
    t_ovr();
    t_sums();
    t_rerst();
    end_sim();
  end
endmodule // test_acr_regs
